// File: logic/tof_pkg.sv
`default_nettype none
package tof_pkg;
  // modes of operation
  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_MULTIZONE = 2'h1;
  localparam logic [1:0] MODE_LITE = 2'h2;
  localparam logic [1:0] MODE_AUTONOMOUS = 2'h3;
  // zone layouts
  localparam logic [1:0] LAYOUT_QUAD = 2'h0;
  localparam logic [1:0] LAYOUT_NINE = 2'h1;
  localparam logic [1:0] LAYOUT_SIXTEEN = 2'h2;
  localparam logic [1:0] LAYOUT_CUSTOM = 2'h3;
  localparam logic [4:0] ZONES_QUAD = 5'h04;
  localparam logic [4:0] ZONES_NINE = 5'h09;
  localparam logic [4:0] ZONES_SIXTEEN = 5'h10;
  localparam logic [4:0] ROI_MIN = 5'h04;
  localparam logic [4:0] ROI_MAX = 5'h10;
  localparam int TARGETS = 4;
  // status codes
  localparam logic [1:0] STAT_OK = 2'h0;
  localparam logic [1:0] STAT_NO_TARGET = 2'h1;
  localparam logic [1:0] STAT_WEAK = 2'h2;
  localparam logic [15:0] XTALK_MM = 16'h0320; // 80 cm
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int RATE_HZ = 60;
  localparam int RANGE_MS = 16;
  localparam int PERIOD_CYC = CLK_HZ / RATE_HZ;
  localparam int RANGE_CYC = CLK_HZ / 1000 * RANGE_MS;
  localparam int BOOT_US = 1200;
  localparam int BOOT_CYC = CLK_HZ / 1_000_000 * BOOT_US;
  localparam logic [3:0] FILT_DEPTH = 4'h3;
  localparam logic [7:0] I2C_ADDR_W = 8'h52;

  typedef struct packed {
    logic [15:0] dist_mm;
    logic [7:0] signal;
    logic [3:0] quality;
    logic [1:0] status;
  } target_s;

  typedef struct packed {
    logic [4:0] zone;
    logic [2:0] count;
    target_s [TARGETS-1:0] tgt;
  } result_s;
endpackage
`default_nettype wire

// File: logic/tof_ranging_control_handshake.sv
`timescale 1ns/10ps
`default_nettype none
module tof_ranging_control_handshake
  import tof_pkg::*;
#(
  parameter int PERIOD_CYCLES = PERIOD_CYC,
  parameter int RANGE_CYCLES = RANGE_CYC,
  parameter int BOOT_CYCLES = BOOT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic shutdown_n_input_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [1:0] mode_in,
  input wire logic [1:0] layout_in,
  input wire logic [4:0] custom_zones_in,
  input wire logic [4:0] roi_size_in,
  input wire logic [15:0] dist_thresh_in,
  input wire logic [7:0] sig_thresh_in,
  input wire logic [15:0] interval_in,
  input wire logic meas_valid_in,
  input wire logic [2:0] meas_count_in,
  input wire target_s [TARGETS-1:0] meas_tgt_in,
  input wire logic result_read_in,
  output logic result_valid_out,
  output result_s result_out,
  output logic result_interrupt_pin_out,
  output logic result_interrupt_pin_oe_b_out,
  output logic result_ready_out,
  output logic [4:0] roi_eff_out,
  output logic bus_enable_out,
  output logic [7:0] bus_addr_out,
  output logic standby_out,
  output logic ranging_out
);
  typedef enum logic [4:0] {
    S_HW_STBY = 5'h01, S_BOOT = 5'h02, S_SW_STBY = 5'h04,
    S_RANGE = 5'h08, S_HOLD = 5'h10
  } state_e;

  state_e state_r;
  logic sd_meta_r, sd_sync_r;
  logic [31:0] cnt_r;
  logic [31:0] gap_r;
  logic [4:0] zone_r;
  logic [4:0] nzones;
  logic [3:0] far_cnt_r [TARGETS];
  target_s [TARGETS-1:0] filt_tgt;
  logic auto_hit;
  logic buf_in_ready;
  logic [1:0] buf_cnt_r;
  result_s buf_r [2];
  logic buf_rd_r, buf_wr_r;
  logic pend_r;
  logic push;

  // shutdown pin comes from outside, so two stages first
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sd_meta_r <= 1'b0;
      sd_sync_r <= 1'b0;
    end else begin
      sd_meta_r <= shutdown_n_input_in;
      sd_sync_r <= sd_meta_r;
    end
  end

  // zone count per layout, custom clamped to the array
  always_comb begin
    case (layout_in)
      LAYOUT_QUAD: nzones = ZONES_QUAD;
      LAYOUT_NINE: nzones = ZONES_NINE;
      LAYOUT_SIXTEEN: nzones = ZONES_SIXTEEN;
      default: nzones = (custom_zones_in == 5'h00) ? 5'h01 :
        (custom_zones_in > ZONES_SIXTEEN ? ZONES_SIXTEEN : custom_zones_in);
    endcase
  end

  // temporal filter: a far return must persist before it is trusted
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < TARGETS; i++) far_cnt_r[i] <= 4'h0;
    end else if (meas_valid_in && state_r == S_RANGE) begin
      for (int i = 0; i < TARGETS; i++) begin
        if (meas_tgt_in[i].dist_mm > XTALK_MM) begin
          if (far_cnt_r[i] != FILT_DEPTH) far_cnt_r[i] <= far_cnt_r[i] + 4'h1;
        end else begin
          far_cnt_r[i] <= 4'h0;
        end
      end
    end
  end

  // error status on missing or weak returns; unconfirmed far flagged weak
  always_comb begin
    for (int i = 0; i < TARGETS; i++) begin
      filt_tgt[i] = meas_tgt_in[i];
      if (i >= int'(meas_count_in)) begin
        filt_tgt[i].status = STAT_NO_TARGET;
        filt_tgt[i].dist_mm = 16'h0000;
      end else if (meas_tgt_in[i].signal == 8'h00) begin
        filt_tgt[i].status = STAT_WEAK;
      end else if (meas_tgt_in[i].dist_mm > XTALK_MM &&
                   far_cnt_r[i] != FILT_DEPTH) begin
        filt_tgt[i].status = STAT_WEAK;
      end
    end
  end

  // autonomous mode reports only if both the distance and the signal thresholds are met
  assign auto_hit = (meas_tgt_in[0].dist_mm <= dist_thresh_in) &&
                    (meas_tgt_in[0].signal >= sig_thresh_in) &&
                    (meas_count_in != 3'h0);
  assign push = (state_r == S_RANGE) && meas_valid_in && buf_in_ready &&
                (mode_in != MODE_AUTONOMOUS || auto_hit);

  // main sequencer
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= S_HW_STBY;
      cnt_r <= 32'h0;
      gap_r <= 32'h0;
      zone_r <= 5'h00;
    end else if (!sd_sync_r) begin
      state_r <= S_HW_STBY;
      cnt_r <= 32'h0;
      zone_r <= 5'h00;
    end else begin
      if (cnt_r != 32'h0) cnt_r <= cnt_r - 32'h1;
      if (gap_r != 32'h0) gap_r <= gap_r - 32'h1;
      case (state_r)
        S_HW_STBY: begin
          state_r <= S_BOOT;
          cnt_r <= 32'(BOOT_CYCLES);
        end
        S_BOOT: if (cnt_r == 32'h0) state_r <= S_SW_STBY;
        S_SW_STBY: if (start_in && gap_r == 32'h0 && !pend_r) begin
          state_r <= S_RANGE;
          cnt_r <= 32'(RANGE_CYCLES);
          gap_r <= (mode_in == MODE_AUTONOMOUS) ?
                   {16'h0000, interval_in} : 32'(PERIOD_CYCLES);
        end
        S_RANGE: if (meas_valid_in && buf_in_ready) begin
          if (mode_in == MODE_MULTIZONE && zone_r + 5'h01 < nzones)
            zone_r <= zone_r + 5'h01;
          else zone_r <= 5'h00;
          state_r <= (mode_in == MODE_AUTONOMOUS) ? S_SW_STBY : S_HOLD;
        end else if (cnt_r == 32'h0) begin
          state_r <= S_SW_STBY; // op timed out, go idle
        end
        S_HOLD: if (!pend_r) state_r <= S_SW_STBY;
        default: state_r <= S_HW_STBY;
      endcase
      if (stop_in && state_r != S_BOOT && state_r != S_HW_STBY)
        state_r <= S_SW_STBY;
    end
  end

  // two-entry result buffer: the host may lag one read
  assign buf_in_ready = (buf_cnt_r != 2'h2);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      buf_cnt_r <= 2'h0;
      buf_rd_r <= 1'b0;
      buf_wr_r <= 1'b0;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end else if (!sd_sync_r) begin
      buf_cnt_r <= 2'h0; // results are lost in shutdown
    end else begin
      if (push) begin
        buf_r[buf_wr_r] <= '{zone: zone_r, count: meas_count_in,
                             tgt: filt_tgt};
        buf_wr_r <= ~buf_wr_r;
      end
      if (result_read_in && buf_cnt_r != 2'h0) buf_rd_r <= ~buf_rd_r;
      buf_cnt_r <= buf_cnt_r + {1'b0, push} -
                   {1'b0, result_read_in && buf_cnt_r != 2'h0};
    end
  end

  // interrupt and ready flag; a new push wins over a read
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_r <= 1'b0;
      result_interrupt_pin_oe_b_out <= 1'b1;
      result_ready_out <= 1'b0;
      result_valid_out <= 1'b0;
      result_out <= '0;
    end else begin
      if (push) pend_r <= 1'b1;
      else if (result_read_in && buf_cnt_r == 2'h1) pend_r <= 1'b0;
      // pin pulled low while result waits, released otherwise
      result_interrupt_pin_oe_b_out <= ~(push || pend_r) | ~sd_sync_r;
      // gated like the pin, so the flag never claims a result in shutdown
      result_ready_out <= (push || pend_r) && sd_sync_r;
      result_valid_out <= (buf_cnt_r != 2'h0);
      result_out <= buf_r[buf_rd_r];
      if (!sd_sync_r) pend_r <= 1'b0;
    end
  end

  // static and status outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      result_interrupt_pin_out <= 1'b0;
      roi_eff_out <= ROI_MAX;
      bus_enable_out <= 1'b0;
      bus_addr_out <= I2C_ADDR_W;
      standby_out <= 1'b1;
      ranging_out <= 1'b0;
    end else begin
      result_interrupt_pin_out <= 1'b0;
      roi_eff_out <= (roi_size_in < ROI_MIN) ? ROI_MIN :
        (roi_size_in > ROI_MAX ? ROI_MAX : roi_size_in);
      bus_enable_out <= sd_sync_r && state_r != S_HW_STBY &&
                        state_r != S_BOOT;
      bus_addr_out <= I2C_ADDR_W;
      standby_out <= (state_r != S_RANGE);
      ranging_out <= (state_r == S_RANGE);
    end
  end

  chk_hold_pend: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_r == S_HOLD && pend_r && sd_sync_r) |=> state_r != S_RANGE)
    else $error("ranging resumed while result pending");
  chk_irq_pin: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    push && sd_sync_r |=> !result_interrupt_pin_oe_b_out)
    else $error("interrupt not pulled after result");
  chk_ready_mirror: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    result_ready_out == !result_interrupt_pin_oe_b_out)
    else $error("ready flag differs from interrupt");
  chk_shut_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !sd_sync_r |=> state_r == S_HW_STBY ##1 !bus_enable_out)
    else $error("not in standby under shutdown");
  chk_roi_clamp: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    roi_eff_out >= ROI_MIN && roi_eff_out <= ROI_MAX)
    else $error("region size out of range");
  chk_zone_bound: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    zone_r < ZONES_SIXTEEN)
    else $error("zone index out of range");
  chk_auto_cond: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    push && mode_in == MODE_AUTONOMOUS |-> auto_hit)
    else $error("autonomous report without threshold");
  chk_boot_stby: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_r == S_BOOT && cnt_r == 32'h0 && sd_sync_r |=> state_r == S_SW_STBY)
    else $error("boot did not end in standby");
  chk_no_tgt: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    meas_count_in == 3'h0 |-> filt_tgt[0].status == STAT_NO_TARGET)
    else $error("missing target without error");
endmodule // tof_ranging_control_handshake
`default_nettype wire

// File: tb/tof_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side: drives shutdown and fetches each result once the pin drops
module tof_host_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic irq_line_in,
  input wire logic off_req_in,
  output logic shutdown_n_out,
  output logic read_out
);
  // shutdown is always driven, never left to float
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) shutdown_n_out <= 1'b1;
    else shutdown_n_out <= !off_req_in;
  end
  // random latency stands for a slow bus; idle edges let the pin settle
  initial begin
    read_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (rst_b_in === 1'b1 && irq_line_in === 1'b0) begin
        repeat ($urandom_range(4, 0)) @(posedge clk_in);
        read_out <= 1'b1;
        @(posedge clk_in);
        read_out <= 1'b0;
        repeat (2) @(posedge clk_in);
      end
    end
  end
endmodule // tof_host_model
`default_nettype wire

// File: tb/tof_ranging_control_handshake_test.sv
`timescale 1ns/10ps
`default_nettype none
module tof_ranging_control_handshake_test import tof_pkg::*; ;
  logic clk_in = 1'b0, rst_b_in = 1'b0, start_in = 1'b0, off_req = 1'b0;
  logic meas_valid_in = 1'b0, stop_in = 1'b0;
  logic [1:0] mode_in = 2'h0, layout_in = 2'h0;
  logic [4:0] custom_zones_in = 5'h01, roi_size_in = 5'h10;
  logic [15:0] dist_thresh_in = 16'h0000, interval_in = 16'h0008;
  logic [7:0] sig_thresh_in = 8'h00, addr;
  logic [2:0] meas_count_in = 3'h0;
  target_s [TARGETS-1:0] meas_tgt_in = '0;
  logic shutdown_n, read_p, valid, oe_b, pin, ready, bus_en, stby, rng;
  logic irq_line;
  logic [4:0] roi;
  result_s res;
  result_s q[$];
  int failures = 0, comparisons = 0, zi = 0, nz = 1, fc = 0, cz = 1;
  always #50 clk_in = ~clk_in;
  // the external pull-up gives the high level
  assign irq_line = oe_b ? 1'b1 : pin;
  tof_ranging_control_handshake #(.PERIOD_CYCLES(20), .RANGE_CYCLES(10),
    .BOOT_CYCLES(5)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .shutdown_n_input_in(shutdown_n), .start_in(start_in), .stop_in(stop_in),
    .mode_in(mode_in), .layout_in(layout_in),
    .custom_zones_in(custom_zones_in), .roi_size_in(roi_size_in),
    .dist_thresh_in(dist_thresh_in), .sig_thresh_in(sig_thresh_in),
    .interval_in(interval_in), .meas_valid_in(meas_valid_in),
    .meas_count_in(meas_count_in), .meas_tgt_in(meas_tgt_in),
    .result_read_in(read_p), .result_valid_out(valid), .result_out(res),
    .result_interrupt_pin_out(pin), .result_interrupt_pin_oe_b_out(oe_b),
    .result_ready_out(ready), .roi_eff_out(roi), .bus_enable_out(bus_en),
    .bus_addr_out(addr), .standby_out(stby), .ranging_out(rng));
  tof_host_model host (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .irq_line_in(irq_line), .off_req_in(off_req),
    .shutdown_n_out(shutdown_n), .read_out(read_p));
  task automatic check_val(string nm, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // flag and pin must agree every cycle
  always @(negedge clk_in) if (rst_b_in) begin
    check_val("ready", 16'(!irq_line), 16'(ready));
    check_val("pin", 16'h0, 16'(pin & !oe_b));
  end
  // each fetch pops the oldest expected result
  always @(posedge clk_in) begin : fetch
    result_s e;
    if (rst_b_in === 1'b1 && read_p === 1'b1) begin
      e = q.size() ? q.pop_front() : '1;
      check_val("count", 16'(e.count), 16'(res.count));
      check_val("valid", 16'h1, 16'(valid));
      if (mode_in == MODE_MULTIZONE)
        check_val("zone", 16'(e.zone), 16'(res.zone));
      for (int i = 0; i < TARGETS; i++) begin
        check_val("dist", e.tgt[i].dist_mm, res.tgt[i].dist_mm);
        check_val("stat", 16'(e.tgt[i].status), 16'(res.tgt[i].status));
        if (i < e.count) check_val("sigq", 16'({e.tgt[i].signal,
          e.tgt[i].quality}), 16'({res.tgt[i].signal, res.tgt[i].quality}));
      end
    end
  end
  // one measurement; irq says whether the host should be told
  task automatic op(input bit irq, input logic [15:0] d0, input logic [7:0] s0);
    result_s e;
    target_s [TARGETS-1:0] t;
    int n;
    // let a start request set on the last edge settle before testing it
    @(negedge clk_in);
    n = $urandom_range(4, 1);
    if (start_in) begin
      for (int k = 0; k < 80 && rng !== 1'b1; k++) @(negedge clk_in);
      check_val("ranging", 16'h1, 16'(rng));
      fc = d0 > XTALK_MM ? fc + 1 : 0;
    end
    e = '0;
    e.zone = 5'(zi);
    e.count = 3'(n);
    for (int i = 0; i < TARGETS; i++) begin
      t[i].dist_mm = i ? 16'($urandom_range(799, 1)) : d0;
      t[i].signal = i == 1 ? 8'h00 : (i ? 8'($urandom_range(255, 1)) : s0);
      t[i].quality = 4'($urandom);
      t[i].status = STAT_OK;
      e.tgt[i].status = STAT_NO_TARGET;
      if (i < n) begin
        e.tgt[i] = t[i];
        // fc counts this return too: trusted once FILT_DEPTH came before
        if (t[i].signal == 0 ||
            (i == 0 && d0 > XTALK_MM && fc <= int'(FILT_DEPTH)))
          e.tgt[i].status = STAT_WEAK;
      end
    end
    @(posedge clk_in);
    meas_valid_in <= 1'b1;
    meas_count_in <= 3'(n);
    meas_tgt_in <= t;
    @(posedge clk_in);
    meas_valid_in <= 1'b0;
    if (irq) q.push_back(e);
    if (irq && mode_in == MODE_MULTIZONE) zi = (zi + 1) % nz;
    repeat (2) @(negedge clk_in);
    check_val("irq", 16'(!irq), 16'(irq_line));
    for (int k = 0; k < 40 && ready === 1'b1; k++) begin
      check_val("held", 16'h0, 16'(rng));
      @(negedge clk_in);
    end
    check_val("cleared", 16'h0, 16'(ready));
  endtask
  // shutdown low stops all, high reboots into software standby
  task automatic cfg(input logic [1:0] md, input logic [1:0] ly);
    @(posedge clk_in);
    start_in <= 1'b0;
    off_req <= 1'b1;
    repeat (6) @(negedge clk_in);
    check_val("off_stby", 16'h1, 16'(stby));
    check_val("off_bus", 16'h0, 16'(bus_en));
    off_req <= 1'b0;
    for (int k = 0; k < 60 && bus_en !== 1'b1; k++) @(negedge clk_in);
    check_val("boot_bus", 16'h1, 16'(bus_en));
    check_val("boot_stby", 16'h1, 16'(stby));
    check_val("addr", 16'(I2C_ADDR_W), 16'(addr));
    zi = 0;
    fc = 0;
    @(posedge clk_in);
    mode_in <= md;
    layout_in <= ly;
    custom_zones_in <= 5'(cz);
    start_in <= 1'b1;
  endtask
  initial begin
    void'($urandom(32'hBDE0));
    repeat (8) @(negedge clk_in);
    check_val("rst_pin", 16'h1, 16'(oe_b));
    check_val("rst_valid", 16'h0, 16'(valid));
    check_val("rst_roi", 16'(ROI_MAX), 16'(roi));
    check_val("rst_stby", 16'h1, 16'(stby));
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    cfg(MODE_STANDARD, LAYOUT_QUAD);
    @(posedge clk_in);
    start_in <= 1'b0;
    // sweep all sizes; the edges of the clamp are the awkward cases
    for (int k = 0; k < 32; k++) begin
      @(posedge clk_in);
      roi_size_in <= 5'(k);
      repeat (3) @(negedge clk_in);
      check_val("roi", k < 4 ? 16'(ROI_MIN) : (k > 16 ? 16'(ROI_MAX) : 16'(k)),
        16'(roi));
    end
    op(0, 16'h0100, 8'h40);
    @(posedge clk_in);
    start_in <= 1'b1;
    for (int k = 0; k < 3; k++)
      op(1, 16'($urandom_range(799, 1)), 8'($urandom_range(255, 1)));
    for (int k = 0; k < 4; k++) op(1, 16'h0384, 8'h80);
    for (int l = 0; l < 4; l++) begin
      cz = $urandom_range(16, 1);
      nz = l == 0 ? 4 : (l == 1 ? 9 : (l == 2 ? 16 : cz));
      cfg(MODE_MULTIZONE, 2'(l));
      for (int k = 0; k <= nz; k++) op(1, 16'h0200, 8'h20);
    end
    cfg(MODE_LITE, LAYOUT_QUAD);
    op(1, 16'h0050, 8'h10);
    // a stop mid-operation must drop back to standby before the timeout
    for (int k = 0; k < 80 && rng !== 1'b1; k++) @(negedge clk_in);
    check_val("stop_pre", 16'h1, 16'(rng));
    @(posedge clk_in);
    stop_in <= 1'b1;
    @(posedge clk_in);
    stop_in <= 1'b0;
    repeat (2) @(negedge clk_in);
    check_val("stop", 16'h0, 16'(rng));
    @(posedge clk_in);
    dist_thresh_in <= 16'h01F4;
    sig_thresh_in <= 8'h64;
    cfg(MODE_AUTONOMOUS, LAYOUT_QUAD);
    op(0, 16'h01F5, 8'hC8);
    op(1, 16'h01F4, 8'h64);
    op(0, 16'h0190, 8'h63);
    end_of_test;
  end
  // watchdog well beyond the expected few thousand cycles
  initial begin
    #4_000_000;
    failures++;
    end_of_test;
  end
endmodule // tof_ranging_control_handshake_test
`default_nettype wire
